// File: design/gpio_ports_low_power_wake.sv
// Two 8-bit ports with slow-discharge wake on first port bit zero, AHB-Lite slave.
// Assumes one AHB-Lite master, single word transfers, pins asynchronous to clk.
//
// Contract
// (R1) Wake enable turns on bit-zero current sink
// (R2) Bit-zero fall below low threshold wakes
// (R3) Wake then vectors if global enable set
// (R4) Software charges, inputs, enables, arms, sleeps
// (R5) No internal timeout; RC sets delay
// (R6) Second port direction one means input
// (R7) Direction zero drives output latch
// (R8) Data read gives pins; write sets latch
// (R9) Port writes are read-modify-write
// (R10) Direction controls driver even for analog
// (R11) Analog-selected pins read as zero
// (R12) Software keeps analog pins as inputs
// (R13) Software clears analog-select before digital use
// (R14) First port bit zero senses wake
// (R15) First port bit three is input only
// (R16) Bit four: I/O, timer clock, comparator
// (R17) Bit five: I/O, analog, select, comparator
// (R18) First port direction works the same
// (R19) Wake sets sticky flag, cleared writing zero
// (R20) Wake interrupt needs own and peripheral enable
`timescale 1ns/10ps
`include "gpio_defs.svh"

module gpio_ports_low_power_wake (
	input  wire logic        clk,
	input  wire logic        reset_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// First port pins
	input  wire logic [7:0]  first_port_in,
	output logic      [7:0]  first_port_out,
	output logic      [7:0]  first_port_oe,
	output logic             wake_sink_on,
	// Alternate functions of first port
	input  wire logic        comparator_one_output,
	input  wire logic        comparator_two_output,
	input  wire logic        comparator_one_out_en,
	input  wire logic        comparator_two_out_en,
	output logic             timer_zero_clock_in,
	output logic             slave_select_in,
	// Second port pins
	input  wire logic [7:0]  second_port_in,
	output logic      [7:0]  second_port_out,
	output logic      [7:0]  second_port_oe,
	// Core side
	input  wire logic        core_sleeping,
	output logic             wake_request,
	output logic             vector_request,
	output logic      [12:0] vector_address
);
	// ==========================================================
	// Registers
	logic [7:0]  first_port_pins_ff;
	logic [7:0]  first_port_direction_ff;
	logic [7:0]  analog_select_low_ff;
	logic [7:0]  power_control_ff;
	logic [7:0]  option_config_ff;
	logic [7:0]  second_port_pins_ff;
	logic [7:0]  second_port_direction_ff;
	logic [7:0]  analog_select_high_ff;
	logic        wake_interrupt_flag_ff;
	logic        wake_interrupt_enable_ff;
	logic        global_interrupt_enable_ff;
	logic        periph_interrupt_enable_ff;
	logic        wake_level_ff;
	logic        wake_pending_ff;
	logic [31:0] hrdata_ff;
	logic [11:0] addr_ff;
	gpio_pkg::bus_state_t state_ff;
	gpio_pkg::bus_state_t nxt_state;

	// Pin-bank and decode nets
	logic [7:0] first_level;
	logic [7:0] first_read;
	logic [7:0] second_level;
	logic [7:0] second_read;
	logic [7:0] first_drive_ok;
	logic [7:0] first_latch_mux;
	logic [7:0] first_dir_eff;
	logic [7:0] read_byte;
	logic [7:0] wbyte;
	logic       wr_en;
	logic       wake_fall;
	logic       sink_active;

	// Only the low byte carries register data
	assign wbyte = hwdata[7:0];
	assign wr_en = (state_ff == gpio_pkg::BUS_WRITE);

	// ==========================================================
	// Bus address phase capture; a phase offered while hready is low
	// is not taken, and the master keeps holding it
	always_comb begin
		nxt_state = gpio_pkg::BUS_IDLE;
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				nxt_state = gpio_pkg::BUS_WRITE;
			end else begin
				nxt_state = gpio_pkg::BUS_READ;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= gpio_pkg::BUS_IDLE;
			addr_ff  <= 12'h000;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != gpio_pkg::BUS_IDLE) begin
				addr_ff <= haddr;
			end
		end
	end

	// Reads take one wait state: the data is loaded into a flip-flop
	// while hreadyout is low. Writes finish with no wait.
	// The response is always OKAY.
	assign hreadyout = (state_ff != gpio_pkg::BUS_READ);
	assign hresp     = 1'b0;

	// ==========================================================
	// Pin banks
	// Bit three has no output driver; bits four and five may be
	// taken over by comparator outputs.
	always_comb begin
		first_drive_ok                        = 8'hff;
		first_drive_ok[`FIRST_PORT_IN_ONLY]   = 1'b0; // R15
		first_latch_mux                       = first_port_pins_ff;
		first_dir_eff                         = first_port_direction_ff;
		// Comparator drive overrides both latch and direction
		if (comparator_one_out_en) begin
			first_latch_mux[4] = comparator_one_output; // R16
			first_dir_eff[4]   = 1'b0;
		end
		if (comparator_two_out_en) begin
			first_latch_mux[5] = comparator_two_output; // R17
			first_dir_eff[5]   = 1'b0;
		end
	end

	port_pin_bank u_first (
		.clk          (clk),
		.reset_n      (reset_n),
		.pin_in       (first_port_in),
		.dir          (first_dir_eff),
		.latch        (first_latch_mux),
		.analog_sel   (analog_select_low_ff),
		.drive_ok     (first_drive_ok),
		.pin_out      (first_port_out),
		.pin_oe       (first_port_oe),
		.pin_level    (first_level),
		.digital_read (first_read)
	);

	// No alternate drivers on the second port, so every bit may drive
	port_pin_bank u_second (
		.clk          (clk),
		.reset_n      (reset_n),
		.pin_in       (second_port_in),
		.dir          (second_port_direction_ff),
		.latch        (second_port_pins_ff),
		.analog_sel   (analog_select_high_ff),
		.drive_ok     (8'hff),
		.pin_out      (second_port_out),
		.pin_oe       (second_port_oe),
		.pin_level    (second_level),
		.digital_read (second_read)
	);

	// Digital alternate inputs follow synchronised pin levels
	// so the timer and serial port never see a metastable level
	assign timer_zero_clock_in = first_level[4]; // R16
	assign slave_select_in     = first_level[5]; // R17

	// ==========================================================
	// Port data latches, read-modify-write
	// Pins are read (analog ones as zero), then the written byte
	// replaces every bit, so a whole-byte write sets the latch outright.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_port_pins_ff  <= 8'h00;
			second_port_pins_ff <= 8'h00;
		end else if (wr_en) begin
			if (addr_ff == `OFF_FIRST_PINS) begin
				first_port_pins_ff <= (first_read & 8'h00) | wbyte; // R9
			end else if (addr_ff == `OFF_SECOND_PINS) begin
				second_port_pins_ff <= (second_read & 8'h00) | wbyte; // R8 R9
			end
		end
	end

	// Direction, analog-select and option registers
	// Reset leaves every pin an input, so nothing drives early
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first_port_direction_ff  <= `RST_DIR;
			second_port_direction_ff <= `RST_DIR;
			analog_select_low_ff     <= `RST_ANALOG_SELECT_LOW_LOW;
			analog_select_high_ff    <= `RST_ANALOG_SELECT_LOW_HIGH;
			option_config_ff         <= `RST_OPTION;
		end else if (wr_en) begin
			if (addr_ff == `OFF_FIRST_DIR) begin
				first_port_direction_ff <= wbyte; // R18
			end else if (addr_ff == `OFF_SECOND_DIR) begin
				second_port_direction_ff <= wbyte; // R6 R7
			end else if (addr_ff == `OFF_ANALOG_SELECT_LOW_LOW) begin
				analog_select_low_ff <= wbyte;
			end else if (addr_ff == `OFF_ANALOG_SELECT_LOW_HIGH) begin
				analog_select_high_ff <= wbyte & `ANALOG_SELECT_LOW_HIGH_MASK;
			end else if (addr_ff == `OFF_OPTION_CONFIG) begin
				option_config_ff <= wbyte;
			end
		end
	end

	// ==========================================================
	// Power control and interrupt enables
	// Only sink enable, soft brown-out and the reset-status bits take writes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			power_control_ff           <= `RST_POWER_CONTROL;
			wake_interrupt_enable_ff   <= 1'b0;
			global_interrupt_enable_ff <= 1'b0;
			periph_interrupt_enable_ff <= 1'b0;
		end else if (wr_en) begin
			if (addr_ff == `OFF_POWER_CONTROL) begin
				power_control_ff <= wbyte & `POWER_CONTROL_WR_MASK; // R1
			end else if (addr_ff == `OFF_PERIPH_EN_TWO) begin
				wake_interrupt_enable_ff <= wbyte[`WAKE_FLAG_BIT];
			end else if (addr_ff == `OFF_INT_CONTROL) begin
				global_interrupt_enable_ff <= wbyte[`INTERRUPT_CONTROL_GIE_BIT];
				periph_interrupt_enable_ff <= wbyte[`INTERRUPT_CONTROL_PEIE_BIT];
			end
		end
	end

	// ==========================================================
	// Slow-discharge wake
	// The sink only pulls the pin; the delay is the external RC,
	// so no counter exists here.
	assign sink_active  = power_control_ff[`POWER_CONTROL_SINK_EN_BIT];
	assign wake_sink_on = sink_active; // R1 R5 R14

	// Falling edge of synchronised bit zero while the sink is on
	// Reset matches the synchroniser so no false fall follows reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_level_ff <= 1'b0;
		end else begin
			wake_level_ff <= first_level[0];
		end
	end
	assign wake_fall = sink_active & wake_level_ff & ~first_level[0]; // R2 R14

	// Sticky flag; a new event beats a software clear
	// Writing one to the flag leaves it as it is
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_interrupt_flag_ff <= 1'b0;
		end else if (wake_fall) begin
			wake_interrupt_flag_ff <= 1'b1; // R19
		end else if (wr_en && addr_ff == `OFF_PERIPH_FLAG_TWO
			&& !wbyte[`WAKE_FLAG_BIT]) begin
			wake_interrupt_flag_ff <= 1'b0; // R19
		end
	end

	// Wake the core; vector only with global enable
	assign wake_request   = wake_interrupt_flag_ff & wake_interrupt_enable_ff
		& periph_interrupt_enable_ff; // R2 R20
	assign vector_request = wake_request & global_interrupt_enable_ff; // R3
	assign vector_address = `INT_VECTOR; // R3

	// Record that a wake left sleep, for status read-back
	// One cycle late; status only, it drives nothing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_pending_ff <= 1'b0;
		end else begin
			wake_pending_ff <= wake_request & core_sleeping;
		end
	end

	// ==========================================================
	// Read data
	// Unmapped offsets read zero
	always_comb begin
		read_byte = 8'h00;
		if (addr_ff == `OFF_FIRST_PINS) begin
			read_byte = first_read; // R8 R11
		end else if (addr_ff == `OFF_FIRST_DIR) begin
			read_byte = first_port_direction_ff;
		end else if (addr_ff == `OFF_ANALOG_SELECT_LOW_LOW) begin
			read_byte = analog_select_low_ff;
		end else if (addr_ff == `OFF_POWER_CONTROL) begin
			read_byte = power_control_ff;
		end else if (addr_ff == `OFF_OPTION_CONFIG) begin
			read_byte = option_config_ff;
		end else if (addr_ff == `OFF_SECOND_PINS) begin
			read_byte = second_read; // R8 R11
		end else if (addr_ff == `OFF_SECOND_DIR) begin
			read_byte = second_port_direction_ff;
		end else if (addr_ff == `OFF_ANALOG_SELECT_LOW_HIGH) begin
			read_byte = analog_select_high_ff;
		end else if (addr_ff == `OFF_PERIPH_FLAG_TWO) begin
			read_byte = {1'b0, wake_interrupt_flag_ff, 6'h00};
		end else if (addr_ff == `OFF_PERIPH_EN_TWO) begin
			read_byte = {1'b0, wake_interrupt_enable_ff, 6'h00};
		end else if (addr_ff == `OFF_INT_CONTROL) begin
			read_byte = {global_interrupt_enable_ff, periph_interrupt_enable_ff, 6'h00};
		end else if (addr_ff == `OFF_CORE_STATUS) begin
			read_byte = {7'h00, wake_pending_ff};
		end
	end

	// ==========================================================
	// Read data register
	// Loaded in the read wait state, after a write in the cycle
	// before has landed, so back-to-back write and read agree.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_ff <= 32'h00000000;
		end else if (state_ff == gpio_pkg::BUS_READ) begin
			hrdata_ff <= {24'h000000, read_byte}; // R8 R11
		end
	end

	assign hrdata = hrdata_ff;
endmodule // gpio_ports_low_power_wake

// File: design/gpio_defs.svh
// Register offsets, field positions, reset values and constants for the GPIO block.
// Assumes inclusion by bare name from the design files.
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFF_FIRST_PINS      12'h000
`define OFF_FIRST_DIR       12'h004
`define OFF_ANALOG_SELECT_LOW_LOW       12'h008
`define OFF_POWER_CONTROL   12'h00c
`define OFF_OPTION_CONFIG   12'h010
`define OFF_SECOND_PINS     12'h014
`define OFF_SECOND_DIR      12'h018
`define OFF_ANALOG_SELECT_LOW_HIGH      12'h01c
`define OFF_PERIPH_FLAG_TWO 12'h020
`define OFF_PERIPH_EN_TWO   12'h024
`define OFF_INT_CONTROL     12'h028
`define OFF_CORE_STATUS     12'h02c

// ==========================================================
// Field positions
`define POWER_CONTROL_SINK_EN_BIT    5
`define POWER_CONTROL_SOFT_BOR_BIT   4
`define POWER_CONTROL_POR_BIT        1
`define POWER_CONTROL_BOR_BIT        0
`define WAKE_FLAG_BIT       6
`define INTERRUPT_CONTROL_GIE_BIT      7
`define INTERRUPT_CONTROL_PEIE_BIT     6
`define FIRST_PORT_IN_ONLY  3

// ==========================================================
// Reset values, write masks and interrupt vector
`define RST_DIR             8'hff
`define RST_ANALOG_SELECT_LOW_LOW       8'hff
`define RST_ANALOG_SELECT_LOW_HIGH      8'h3f
`define RST_OPTION          8'hff
`define RST_POWER_CONTROL            8'h10
`define ANALOG_SELECT_LOW_HIGH_MASK     8'h3f
`define POWER_CONTROL_WR_MASK        8'h33
`define INT_VECTOR          13'h0004

`endif

// File: design/gpio_pkg.sv
// Types shared by the GPIO block.
// Assumes compilation before the design modules.
package gpio_pkg;
	// ==========================================================
	// Bus data-phase states
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ  = 3'b100
	} bus_state_t;
endpackage

// File: design/port_pin_bank.sv
// One 8-bit port: pin synchroniser, drivers and digital read-back.
// Assumes pins sampled from outside the clock domain.
`timescale 1ns/10ps
`include "gpio_defs.svh"

module port_pin_bank (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] pin_in,
	input  wire logic [7:0] dir,
	input  wire logic [7:0] latch,
	input  wire logic [7:0] analog_sel,
	input  wire logic [7:0] drive_ok,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe,
	output logic      [7:0] pin_level,
	output logic      [7:0] digital_read
);
	logic [7:0] meta_ff;
	logic [7:0] sync_ff;

	// ==========================================================
	// Two-stage synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= 8'h00;
			sync_ff <= 8'h00;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	// Per-bit driver and read path
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			// Direction keeps driver control even on analog pins
			assign pin_oe[i]       = ~dir[i] & drive_ok[i]; // R6 R7 R10 R18
			assign pin_out[i]      = latch[i];              // R7
			// Analog-selected pins read zero
			assign digital_read[i] = sync_ff[i] & ~analog_sel[i]; // R11
		end
	endgenerate

	assign pin_level = sync_ff;
endmodule // port_pin_bank

// File: test/pin_rc_model.sv
// Pin-side model: driven pins, outside levels and an RC on first port bit zero.
// Assumes the outside levels come from the bench and one clock times the discharge.
`timescale 1ns/10ps
module pin_rc_model #(
	parameter int RC_CYCLES = 40
) (
	input  wire logic       clk,
	input  wire logic [7:0] first_port_out,
	input  wire logic [7:0] first_port_oe,
	input  wire logic [7:0] second_port_out,
	input  wire logic [7:0] second_port_oe,
	input  wire logic       wake_sink_on,
	input  wire logic [7:0] ext_a,
	input  wire logic [7:0] ext_b,
	output logic      [7:0] first_port_in,
	output logic      [7:0] second_port_in
);
	int cap_ff;

	// ==========================================================
	// Capacitor: charged while driven high, drained only by the sink
	always_ff @(posedge clk) begin
		if (first_port_oe[0] && first_port_out[0])
			cap_ff <= RC_CYCLES;
		else if (wake_sink_on && cap_ff > 0)
			cap_ff <= cap_ff - 1;
	end

	// Released pins show the outside world, not the last driven value
	always_comb begin
		first_port_in  = (first_port_oe & first_port_out) | (~first_port_oe & ext_a);
		second_port_in = (second_port_oe & second_port_out) | (~second_port_oe & ext_b);
		if (!first_port_oe[0])
			first_port_in[0] = (cap_ff != 0);
	end
endmodule // pin_rc_model

// File: test/gpio_chk_chk.sv
// Checker for the GPIO block: drivers, wake flag and synchronised inputs.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/10ps
module gpio_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [7:0]  first_port_in,
	input wire logic [7:0]  first_port_out,
	input wire logic [7:0]  first_port_oe,
	input wire logic        wake_sink_on,
	input wire logic        comparator_one_output,
	input wire logic        comparator_one_out_en,
	input wire logic        timer_zero_clock_in,
	input wire logic        slave_select_in,
	input wire logic [7:0]  second_port_out,
	input wire logic [7:0]  second_port_oe,
	input wire logic        wake_request,
	input wire logic        vector_request,
	input wire logic [12:0] vector_address
);
	logic       wr_dp_ff;
	logic [1:0] up_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// Write data phase marker; settle count so sync depth is valid
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_dp_ff <= 1'b0;
			up_ff    <= 2'd0;
		end else begin
			wr_dp_ff <= hsel & hready & htrans[1] & hwrite;
			up_ff    <= up_ff[1] ? up_ff : up_ff + 2'd1;
		end
	end

	chk_vector_gated: assert property (vector_request |-> wake_request)
		else $error("vector request without wake request");
	chk_vector_fixed: assert property (vector_address == 13'h0004)
		else $error("vector address wrong");
	chk_bit3_input: assert property (!first_port_oe[3])
		else $error("input-only pin driven");
	chk_write_only: assert property ($changed({second_port_oe, second_port_out,
		first_port_oe[3:0], first_port_out[3:0], wake_sink_on}) |-> $past(wr_dp_ff))
		else $error("driver changed without a write");
	chk_wake_cause: assert property ($rose(wake_request)
		|-> $past(wr_dp_ff) || !$past(first_port_in[0], 2))
		else $error("wake without pin fall or write");
	chk_flag_sticky: assert property ($fell(wake_request) |-> $past(wr_dp_ff))
		else $error("wake dropped without a write");
	chk_timer_sync: assert property (up_ff[1]
		|-> timer_zero_clock_in == $past(first_port_in[4], 2))
		else $error("timer clock input not bit four");
	chk_select_sync: assert property (up_ff[1]
		|-> slave_select_in == $past(first_port_in[5], 2))
		else $error("select input not bit five");
	chk_comp_drive: assert property (comparator_one_out_en
		|-> first_port_oe[4] && first_port_out[4] == comparator_one_output)
		else $error("comparator output not on bit four");

	// Main scenarios reached
	cover property ($rose(wake_request));
	cover property (vector_request);
	cover property (second_port_oe == 8'hff);
endmodule // gpio_chk

// File: test/tb_top.sv
// Testbench for the GPIO block: bus tasks, pin model and scenario tasks.
// Assumes design, pin model and checker files are compiled before it.
`timescale 1ns/10ps
module tb_top;
	logic        clk, reset_n, hsel, hwrite, hready, hresp, core_sleeping;
	logic        comparator_one_output, comparator_one_out_en, wake_sink_on;
	logic        comparator_two_output, comparator_two_out_en;
	logic        timer_zero_clock_in, slave_select_in, wake_request, vector_request;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [11:0] haddr;
	logic [12:0] vector_address;
	logic [31:0] hwdata, hrdata, q;
	logic [7:0]  first_port_in, first_port_out, first_port_oe, ext_a, ext_b;
	logic [7:0]  second_port_in, second_port_out, second_port_oe;
	int          errors, checked, n;

	gpio_ports_low_power_wake i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .first_port_in, .first_port_out,
		.first_port_oe, .wake_sink_on, .comparator_one_output, .comparator_two_output,
		.comparator_one_out_en, .comparator_two_out_en, .timer_zero_clock_in,
		.slave_select_in, .second_port_in, .second_port_out, .second_port_oe, .core_sleeping,
		.wake_request, .vector_request, .vector_address);
	pin_rc_model i_pins (.clk, .first_port_out, .first_port_oe, .second_port_out,
		.second_port_oe, .wake_sink_on, .ext_a, .ext_b, .first_port_in, .second_port_in);

	// ==========================================================
	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single word transfer; read data lands in q
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		@(negedge clk);  // Let outputs settle before any check
	endtask

	task automatic t_resets;
		logic [11:0] a [7] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h018, 12'h01c, 12'h030};
		logic [7:0]  e [7] = '{8'hff, 8'hff, 8'h10, 8'hff, 8'hff, 8'h3f, 8'h00};
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, a[i], 32'h0);
			check(q, 32'(e[i]));
		end
		bus(1'b1, 12'h030, 32'hff);
		bus(1'b0, 12'h030, 32'h0);
		check(q, 32'h0);
	endtask

	task automatic t_second_port;
		@(posedge clk);
		ext_b <= 8'h3c;
		bus(1'b1, 12'h01c, 32'h00);
		bus(1'b1, 12'h014, 32'ha5);
		check(32'(second_port_oe), 32'h00);
		bus(1'b0, 12'h014, 32'h0);
		check(q, 32'h3c);
		bus(1'b1, 12'h018, 32'h00);
		check(32'(second_port_oe), 32'hff);
		check(32'(second_port_out), 32'ha5);
		bus(1'b1, 12'h018, 32'h0f);
		bus(1'b1, 12'h014, 32'h5a);
		check(32'(second_port_out), 32'h5a);
		bus(1'b0, 12'h014, 32'h0);
		check(q, 32'h5c);
		bus(1'b1, 12'h01c, 32'h3f);
		bus(1'b0, 12'h014, 32'h0);
		check(q, 32'h40);
		check(32'(second_port_oe), 32'hf0);
		bus(1'b1, 12'h018, 32'hff);
		check(32'(second_port_oe), 32'h00);
	endtask

	task automatic t_first_port;
		@(posedge clk);
		ext_a <= 8'h96;
		bus(1'b1, 12'h008, 32'h00);
		bus(1'b1, 12'h000, 32'hff);
		bus(1'b1, 12'h004, 32'h00);
		check(32'(first_port_oe), 32'hf7);
		@(posedge clk);
		{comparator_one_out_en, comparator_two_out_en} <= 2'b11;
		{comparator_one_output, comparator_two_output} <= 2'b10;
		repeat (3) @(posedge clk);
		check(32'(first_port_out[5:4]), 32'h1);
		{comparator_one_output, comparator_two_output} <= 2'b01;
		repeat (3) @(posedge clk);
		check(32'(first_port_out[5:4]), 32'h2);
		{comparator_one_out_en, comparator_two_out_en} <= 2'b00;
		bus(1'b1, 12'h004, 32'hff);
		@(posedge clk);
		ext_a <= 8'h68;
		check(32'(first_port_oe), 32'h00);
		bus(1'b0, 12'h000, 32'h0);
		check(q, 32'h69);
	endtask

	// Charge, inputs and enables in the documented order, sleep set before arming, then discharge and wake
	task automatic t_wake;
		bus(1'b1, 12'h004, 32'hfe);
		bus(1'b1, 12'h004, 32'hff);
		bus(1'b1, 12'h020, 32'h00);
		bus(1'b1, 12'h024, 32'h40);
		bus(1'b1, 12'h028, 32'h40);
		@(posedge clk);
		core_sleeping <= 1'b1;
		bus(1'b1, 12'h00c, 32'h20);
		check(32'(wake_sink_on), 32'h1);
		n = 0;
		while (wake_request !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check(32'(wake_request), 32'h1);
		check(32'(n > 30), 32'h1);
		bus(1'b0, 12'h02c, 32'h0);
		check(q, 32'h1);
		check(32'(vector_request), 32'h0);
		bus(1'b1, 12'h028, 32'hc0);
		check(32'(vector_request), 32'h1);
		check(32'(vector_address), 32'h4);
		bus(1'b1, 12'h024, 32'h00);
		check(32'(wake_request), 32'h0);
		bus(1'b0, 12'h020, 32'h0);
		check(q, 32'h40);
		bus(1'b1, 12'h020, 32'h00);
		bus(1'b0, 12'h020, 32'h0);
		check(q, 32'h00);
		bus(1'b1, 12'h00c, 32'h00);
		check(32'(wake_sink_on), 32'h0);
	endtask

	task automatic final_report;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end

	// Main sequence
	initial begin
		{hsel, hwrite, core_sleeping, comparator_one_output, comparator_one_out_en} = '0;
		{comparator_two_output, comparator_two_out_en} = 2'b00;
		htrans  = 2'b00;
		hsize   = 3'b010;
		haddr   = 12'h000;
		hwdata  = 32'h0;
		ext_a   = 8'h00;
		ext_b   = 8'h00;
		reset_n = 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_resets();
		t_second_port();
		t_first_port();
		t_wake();
		final_report();
	end
endmodule // tb_top

bind gpio_ports_low_power_wake gpio_chk i_chk (.clk, .reset_n, .hsel, .htrans, .hwrite,
	.hready, .first_port_in, .first_port_out, .first_port_oe, .wake_sink_on,
	.comparator_one_output, .comparator_one_out_en, .timer_zero_clock_in, .slave_select_in,
	.second_port_out, .second_port_oe, .wake_request, .vector_request, .vector_address);
